// >>> tsf_top.sv
// Purpose: Tamper input sampling, filtering, detection flags and interrupt
// Assumes: sys_rst is the backup domain reset; slow_tick pulses once per slow clock
// Notes:   Register port with read data one cycle after the read strobe
`include "tsf_defines.svh"
`default_nettype none
module tsf_top (
  input  wire logic                  clk,             // System clock
  input  wire logic                  sys_rst,         // Backup domain reset
  input  wire logic                  slow_tick,       // Slow clock enable
  input  wire logic [7:0]            reg_addr,        // Register byte address
  input  wire logic [31:0]           reg_wdata,       // Write data
  input  wire logic                  reg_wr,          // Write strobe
  input  wire logic                  reg_rd,          // Read strobe
  output logic      [31:0]           reg_rdata,       // Read data
  input  wire tsf_pkg::tsf_ext_type  tamper_pin_x,    // External tamper pins
  input  wire tsf_pkg::tsf_ext_type  ext_active_evt,  // Events of active-mode inputs
  input  wire tsf_pkg::tsf_int_type  int_src_evt,     // Internal source events
  output tsf_pkg::tsf_ext_type       pullup_en,       // Pin pull-up enables
  output logic                       tamper_irq,      // Interrupt level
  output logic                       tamper_trigger,  // Trigger pulse
  output logic                       bkp_erase_req    // Backup erase pulse
);

  // Configuration state
  logic [7:0]            cfg_reg;
  tsf_pkg::tsf_ext_type  level_reg;
  tsf_pkg::tsf_ext_type  mask_reg;
  tsf_pkg::tsf_ext_type  mode_reg;
  tsf_pkg::tsf_ext_type  ext_ie_reg;
  tsf_pkg::tsf_int_type  int_ie_reg;

  // Flags
  tsf_pkg::tsf_ext_type  ext_flag_reg;
  tsf_pkg::tsf_int_type  int_flag_reg;
  tsf_pkg::tsf_ext_type  ext_flag_next;
  tsf_pkg::tsf_int_type  int_flag_next;

  // Event and decode wires
  tsf_pkg::tsf_ext_type  filt_evt;
  tsf_pkg::tsf_ext_type  ext_set;
  tsf_pkg::tsf_ext_type  passive;
  tsf_pkg::tsf_ext_type  ext_clr;
  tsf_pkg::tsf_int_type  int_clr;
  logic                  wr_cfg;
  logic                  wr_ctrl;
  logic                  wr_ier;
  logic                  wr_clr;
  logic                  rd_sr;
  logic [31:0]           flags_word;
  logic [31:0]           ier_word;
  logic [31:0]           rd_mux;

  tsf_sample_if sif ();

  // Address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Register decode
  assign wr_cfg  = reg_wr && hit(reg_addr, `TSF_OFS_FILTER_CFG);
  assign wr_ctrl = reg_wr && hit(reg_addr, `TSF_OFS_CTRL);
  assign wr_ier  = reg_wr && hit(reg_addr, `TSF_OFS_IRQ_ENABLE);
  assign wr_clr  = reg_wr && hit(reg_addr, `TSF_OFS_FLAG_CLEAR);
  assign rd_sr   = reg_rd && hit(reg_addr, `TSF_OFS_EVENT_FLAGS);

  // Mode select 0 is passive
  assign passive = ~mode_reg;

  // Shared settings to timer and filters
  assign sif.precharge_disable = cfg_reg[`TSF_PUD_BIT];
  assign sif.precharge_len     = cfg_reg[`TSF_PRCH_LSB +: 2];
  assign sif.filter_count_sel  = cfg_reg[`TSF_FLT_LSB +: 2];
  assign sif.sample_rate_sel   = cfg_reg[`TSF_FREQ_LSB +: 3];

  // Sample divider and precharge window
  tsf_sample_timer u_timer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .slow_tick (slow_tick),
    .sif       (sif)
  );

  // One filter per external input
  for (genvar i = 0; i < 3; i++) begin : g_filt
    tsf_pin_filter u_filt (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .pin       (tamper_pin_x[i]),
      .level_sel (level_reg[i]),
      .enable    (passive[i]),
      .sif       (sif),
      .event_out (filt_evt[i])
    );
  end

  // Filter events only from passive inputs
  assign ext_set = (filt_evt & passive) | (ext_active_evt & mode_reg);

  // Filter configuration register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= 8'(`TSF_RST_VAL);
    end else if (wr_cfg) begin
      cfg_reg <= reg_wdata[7:0];
    end
  end

  // Level, mask and mode control register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_reg <= 3'h0;
      mask_reg  <= 3'h0;
      mode_reg  <= 3'h0;
    end else if (wr_ctrl) begin
      level_reg <= reg_wdata[`TSF_LVL_LSB +: 3];
      mask_reg  <= reg_wdata[`TSF_MSK_LSB +: 3];
      mode_reg  <= reg_wdata[`TSF_MODE_LSB +: 3];
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_ie_reg <= 3'h0;
      int_ie_reg <= 4'h0;
    end else if (wr_ier) begin
      ext_ie_reg <= reg_wdata[`TSF_EXT_LSB +: 3];
      int_ie_reg <= reg_wdata[`TSF_INT_LSB +: 4];
    end
  end

  // Clears from the clear register or a flag register read
  assign ext_clr = ({3{wr_clr}} & reg_wdata[`TSF_EXT_LSB +: 3])
                 | {3{rd_sr}};
  assign int_clr = ({4{wr_clr}} & reg_wdata[`TSF_INT_LSB +: 4])
                 | {4{rd_sr}};

  // Set wins over clear; masked inputs drop their flag next cycle
  assign ext_flag_next = ext_set
                       | (ext_flag_reg & ~ext_clr & ~mask_reg);
  assign int_flag_next = int_src_evt | (int_flag_reg & ~int_clr);

  // Detection flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_flag_reg <= 3'h0;
      int_flag_reg <= 4'h0;
    end else begin
      ext_flag_reg <= ext_flag_next;
      int_flag_reg <= int_flag_next;
    end
  end

  // Interrupt level from masked flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tamper_irq <= 1'b0;
    end else begin
      tamper_irq <= |(ext_flag_reg & ext_ie_reg)
                  | |(int_flag_reg & int_ie_reg);
    end
  end

  // Trigger and backup erase pulses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tamper_trigger <= 1'b0;
      bkp_erase_req  <= 1'b0;
    end else begin
      tamper_trigger <= |ext_set | |int_src_evt;
      bkp_erase_req  <= |(ext_set & ~mask_reg) | |int_src_evt;
    end
  end

  // Pull-ups only on passive inputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pullup_en <= 3'h0;
    end else begin
      pullup_en <= {3{sif.pullup_on}} & passive;
    end
  end

  // Word views of flags and enables
  always_comb begin
    flags_word = `TSF_RST_VAL;
    flags_word[`TSF_EXT_LSB +: 3] = ext_flag_reg;
    flags_word[`TSF_INT_LSB +: 4] = int_flag_reg;
    ier_word = `TSF_RST_VAL;
    ier_word[`TSF_EXT_LSB +: 3] = ext_ie_reg;
    ier_word[`TSF_INT_LSB +: 4] = int_ie_reg;
  end

  // Read multiplexer
  always_comb begin
    rd_mux = `TSF_RST_VAL;
    unique case (reg_addr)
      `TSF_OFS_FILTER_CFG: begin
        rd_mux = {24'h000000, cfg_reg};
      end
      `TSF_OFS_CTRL: begin
        rd_mux[`TSF_LVL_LSB +: 3]  = level_reg;
        rd_mux[`TSF_MSK_LSB +: 3]  = mask_reg;
        rd_mux[`TSF_MODE_LSB +: 3] = mode_reg;
      end
      `TSF_OFS_IRQ_ENABLE: begin
        rd_mux = ier_word;
      end
      `TSF_OFS_EVENT_FLAGS: begin
        rd_mux = flags_word;
      end
      `TSF_OFS_MASKED_IRQ: begin
        rd_mux = flags_word & ier_word;
      end
      default: begin
        rd_mux = `TSF_RST_VAL;
      end
    endcase
  end

  // Read data register, zero when no read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `TSF_RST_VAL;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= `TSF_RST_VAL;
    end
  end

endmodule
`default_nettype wire

// >>> tsf_defines.svh
// Purpose: Offsets, field positions and reset values of the tamper filter block
// Assumes: Included by bare name; definitions only
// Notes:   Byte offsets on the register port
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH

// Register offsets
`define TSF_OFS_CTRL        8'h04
`define TSF_OFS_FILTER_CFG  8'h0c
`define TSF_OFS_IRQ_ENABLE  8'h2c
`define TSF_OFS_EVENT_FLAGS 8'h30
`define TSF_OFS_MASKED_IRQ  8'h34
`define TSF_OFS_FLAG_CLEAR  8'h3c

// Filter configuration fields
`define TSF_PUD_BIT         7
`define TSF_PRCH_LSB        5
`define TSF_FLT_LSB         3
`define TSF_FREQ_LSB        0
`define TSF_CFG_MASK        32'h0000_00ff

// Control fields
`define TSF_LVL_LSB         24
`define TSF_MSK_LSB         16
`define TSF_MODE_LSB        8
`define TSF_CTRL_MASK       32'h0707_0700

// Flag layout: external 2:0, internal 21:18
`define TSF_EXT_LSB         0
`define TSF_INT_LSB         18
`define TSF_FLAG_MASK       32'h003c_0007

// Reset values and timing counts
`define TSF_RST_VAL         32'h0000_0000
`define TSF_PERIOD_MAX_M1   15'h7fff

`endif

// >>> tsf_pkg.sv
// Purpose: Shared types of the tamper filter block
// Assumes: Nothing imported; users write tsf_pkg::name
// Notes:   Field widths only
`default_nettype none
package tsf_pkg;
  typedef logic [2:0] tsf_ext_type;
  typedef logic [3:0] tsf_int_type;
  typedef logic [1:0] tsf_flt_type;
  typedef logic [2:0] tsf_rate_type;
endpackage
`default_nettype wire

// >>> tsf_sample_if.sv
// Purpose: Sample timing and shared filter settings between timer, filters and top
// Assumes: One clock domain
// Notes:   Settings are shared by all external inputs
`default_nettype none
interface tsf_sample_if;
  logic                 sample_tick;
  logic                 pullup_on;
  logic                 precharge_disable;
  logic [1:0]           precharge_len;
  tsf_pkg::tsf_flt_type filter_count_sel;
  tsf_pkg::tsf_rate_type sample_rate_sel;
  modport timer (output sample_tick, output pullup_on, input precharge_disable,
                 input precharge_len, input filter_count_sel, input sample_rate_sel);
  modport filt (input sample_tick, input filter_count_sel);
endinterface
`default_nettype wire

// >>> tsf_sample_timer.sv
// Purpose: Sample-rate divider and precharge window on slow clock ticks
// Assumes: slow_tick is a one-cycle pulse per slow_clock cycle
// Notes:   Pull-up window ends on the sample tick itself
`include "tsf_defines.svh"
`default_nettype none
module tsf_sample_timer (
  input  wire logic   clk,        // System clock
  input  wire logic   sys_rst,    // Backup domain reset
  input  wire logic   slow_tick,  // Slow clock enable
  tsf_sample_if.timer sif         // Timing to filters
);
  logic [14:0] div_reg;
  logic [14:0] period_m1;
  logic [14:0] remain;
  logic [3:0]  prch_cycles;

  // Period minus one and cycles left before sample
  assign period_m1   = `TSF_PERIOD_MAX_M1 >> sif.sample_rate_sel;
  assign remain      = (div_reg > period_m1) ? 15'h0000 : period_m1 - div_reg;
  assign prch_cycles = 4'h1 << sif.precharge_len;

  // Divider and sample pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg         <= 15'h0000;
      sif.sample_tick <= 1'b0;
    end else begin
      sif.sample_tick <= 1'b0;
      if (slow_tick) begin
        if (div_reg >= period_m1) begin
          div_reg         <= 15'h0000;
          sif.sample_tick <= 1'b1;
        end else begin
          div_reg <= div_reg + 15'h0001;
        end
      end
    end
  end

  // Precharge window, none in edge mode or when disabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sif.pullup_on <= 1'b0;
    end else begin
      sif.pullup_on <= !sif.precharge_disable && (sif.filter_count_sel != 2'h0)
                       && (remain < {11'h000, prch_cycles});
    end
  end
endmodule
`default_nettype wire

// >>> tsf_pin_filter.sv
// Purpose: Edge detect or consecutive-sample filter for one external input
// Assumes: Pin level is synchronous to clk
// Notes:   One event per run of active samples
`default_nettype none
module tsf_pin_filter (
  input  wire logic  clk,        // System clock
  input  wire logic  sys_rst,    // Backup domain reset
  input  wire logic  pin,        // Tamper pin level
  input  wire logic  level_sel,  // Active level select
  input  wire logic  enable,     // Passive mode in use
  tsf_sample_if.filt sif,        // Shared sample timing
  output logic       event_out   // One-cycle detection
);
  logic       active;
  logic       prev_reg;
  logic [3:0] run_reg;

  // Samples needed for an event
  function automatic logic [3:0] need_cnt(input logic [1:0] sel);
    need_cnt = 4'h1 << sel;
  endfunction

  // Edge mode: sel 0 is high; filter mode: sel 0 is low
  assign active = (sif.filter_count_sel == 2'h0) ? (pin ^ level_sel)
                                                 : (pin ~^ level_sel);

  // Sample history and event
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg  <= 1'b0;
      run_reg   <= 4'h0;
      event_out <= 1'b0;
    end else begin
      event_out <= 1'b0;
      if (sif.sample_tick && enable) begin
        prev_reg <= active;
        if (sif.filter_count_sel == 2'h0) begin
          event_out <= active && !prev_reg;
          run_reg   <= 4'h0;
        end else if (!active) begin
          run_reg <= 4'h0;
        end else if (run_reg < need_cnt(sif.filter_count_sel)) begin
          run_reg   <= run_reg + 4'h1;
          event_out <= (run_reg == need_cnt(sif.filter_count_sel) - 4'h1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tsf_properties.sv
// Purpose: Port-level properties of the tamper filter block
// Assumes: Sees only tsf_top ports; register writes are shadowed here
// Notes:   Bound to tsf_top from the bench top file
`default_nettype none
module tsf_properties (
  input wire logic                 clk,            // Clock
  input wire logic                 sys_rst,        // Backup reset
  input wire logic                 slow_tick,      // Slow enable
  input wire logic [7:0]           reg_addr,       // Address
  input wire logic [31:0]          reg_wdata,      // Write data
  input wire logic                 reg_wr,         // Write strobe
  input wire logic                 reg_rd,         // Read strobe
  input wire logic [31:0]          reg_rdata,      // Read data
  input wire tsf_pkg::tsf_ext_type ext_active_evt, // Active events
  input wire tsf_pkg::tsf_int_type int_src_evt,    // Internal events
  input wire tsf_pkg::tsf_ext_type pullup_en,      // Pull-ups
  input wire logic                 tamper_irq,     // Interrupt
  input wire logic                 tamper_trigger, // Trigger
  input wire logic                 bkp_erase_req   // Erase
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cfg_reg;
  logic [31:0] ier_reg;
  logic [31:0] ctl_reg;
  logic [3:0]  hi_cnt;
  // Shadows of the written settings
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= 32'h0;
      ier_reg <= 32'h0;
      ctl_reg <= 32'h0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h0c) cfg_reg <= reg_wdata;
      if (reg_addr == 8'h2c) ier_reg <= reg_wdata & 32'h003c_0007;
      if (reg_addr == 8'h04) ctl_reg <= reg_wdata;
    end
  end
  // Slow ticks inside one precharge window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) hi_cnt <= 4'h0;
    else if (!pullup_en[0]) hi_cnt <= 4'h0;
    else if (slow_tick && hi_cnt != 4'hf) hi_cnt <= hi_cnt + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_int_hit;
    (int_src_evt & ier_reg[21:18]) != 4'h0 && !reg_wr;
  endsequence
  sequence s_masked_only;
    (ext_active_evt & ctl_reg[10:8] & ctl_reg[18:16]) != 3'h0 &&
    (ext_active_evt & ctl_reg[10:8] & ~ctl_reg[18:16]) == 3'h0 && int_src_evt == 4'h0;
  endsequence
  a_int_irq: assert property (s_int_hit |-> ##2 tamper_irq)
    else $error("irq missing after enabled event");
  a_pud_nopull: assert property (cfg_reg[7] [*3] |-> pullup_en == 3'h0)
    else $error("pull-up while disabled");
  a_edge_nopull: assert property ((cfg_reg[4:3] == 2'h0) [*3] |-> pullup_en == 3'h0)
    else $error("pull-up in edge mode");
  a_mode_nopull: assert property (ctl_reg[8] [*3] |-> !pullup_en[0])
    else $error("pull-up on active-mode input");
  a_pull_len: assert property (hi_cnt <= 4'h9)
    else $error("precharge window too long");
  a_misr_sub: assert property (reg_rd && reg_addr == 8'h34 |=>
    (reg_rdata & ~$past(ier_reg)) == 32'h0)
    else $error("masked flag without enable");
  a_irq_off: assert property ((ier_reg == 32'h0) [*3] |-> !tamper_irq)
    else $error("irq with all enables off");
  a_evt_trig: assert property ((int_src_evt != 4'h0) ||
    ((ext_active_evt & ctl_reg[10:8]) != 3'h0) |=> tamper_trigger)
    else $error("trigger missing after event");
  a_mask_noerase: assert property (s_masked_only |=> !bkp_erase_req)
    else $error("erase on masked input");
endmodule
`default_nettype wire

// >>> tsf_pin_model.sv
// Purpose: Sensing circuits on the three tamper pins
// Assumes: A driven pin follows its circuit level
// Notes:   Undriven pin without pull-up wanders every cycle
`default_nettype none
module tsf_pin_model (
  input  wire logic                 clk,       // Clock
  input  wire tsf_pkg::tsf_ext_type pullup_en, // Block pull-ups
  input  wire tsf_pkg::tsf_ext_type drv_en,    // Circuit drives
  input  wire tsf_pkg::tsf_ext_type drv_lvl,   // Circuit level
  output tsf_pkg::tsf_ext_type      pin        // Pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] float_reg = 3'h0;
  // Floating level flips so an open pin never looks stable
  always @(posedge clk) float_reg <= ~pin;
  // Circuit level, else pull-up, else floating
  assign pin = (drv_en & drv_lvl) | (~drv_en & (pullup_en | float_reg));
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench of the tamper filter block
// Assumes: Slow enable every second clock; circuits drive the pins
// Notes:   Inactive pin level is high while filtering
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 slow_tick = 1'b0;
  logic [7:0]           reg_addr = 8'h00;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [31:0]          reg_rdata;
  tsf_pkg::tsf_ext_type pins;
  tsf_pkg::tsf_ext_type pullup_en;
  tsf_pkg::tsf_ext_type drv_lvl = 3'h7;
  tsf_pkg::tsf_ext_type ext_active_evt = 3'h0;
  tsf_pkg::tsf_int_type int_src_evt = 4'h0;
  logic                 tamper_irq;
  logic                 tamper_trigger;
  logic                 bkp_erase_req;
  int                   n_mismatch = 0;
  int                   checks_done = 0;
  always #25 clk = ~clk;
  always @(posedge clk) slow_tick <= ~slow_tick;
  tsf_top u_dut (.clk(clk), .sys_rst(sys_rst), .slow_tick(slow_tick), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tamper_pin_x(pins), .ext_active_evt(ext_active_evt), .int_src_evt(int_src_evt),
    .pullup_en(pullup_en), .tamper_irq(tamper_irq), .tamper_trigger(tamper_trigger),
    .bkp_erase_req(bkp_erase_req));
  tsf_pin_model u_pins (.clk(clk), .pullup_en(pullup_en), .drv_en(3'h7),
    .drv_lvl(drv_lvl), .pin(pins));
  // Verdict and end of run
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    int_src_evt <= v;
    @(posedge clk);
    int_src_evt <= 4'h0;
    repeat (2) @(posedge clk);
  endtask
  // End of next precharge window: cycles waited, cycles high
  task automatic wfall(output int gap, output int hi);
    gap = 0;
    hi = 0;
    while (!(hi > 0 && !pullup_en[0])) begin
      @(posedge clk);
      #1 gap++;
      if (pullup_en[0]) hi++;
      if (gap > 5000) begin
        n_mismatch++;
        finish_test();
      end
    end
  endtask
  task automatic t_regs();
    for (int a = 0; a < 4; a++) rdc(8'h0c + 8'(a == 0 ? 0 : 28 + 4 * a), 32'h0);
    wr(8'h0c, 32'hffff_ffff);
    wr(8'h2c, 32'hffff_ffff);
    wr(8'h30, 32'hffff_ffff);
    rdc(8'h0c, 32'h0000_00ff);
    rdc(8'h2c, 32'h003c_0007);
    rdc(8'h30, 32'h0);
    rdc(8'h50, 32'h0);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(8'h0c, 32'h0);
    rdc(8'h2c, 32'h0);
  endtask
  task automatic t_int();
    wr(8'h2c, 32'h003c_0000);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i);
      chk(tamper_irq, 1'b1);
      rdc(8'h34, 32'h1 << (18 + i));
      rdc(8'h30, 32'h1 << (18 + i));
      repeat (2) @(posedge clk);
      #1 chk(tamper_irq, 1'b0);
    end
    pulse(4'h1);
    wr(8'h3c, 32'h0);
    rdc(8'h34, 32'h0004_0000);
    wr(8'h3c, 32'h0004_0000);
    rdc(8'h34, 32'h0);
    wr(8'h2c, 32'h7);
  endtask
  task automatic t_filt();
    int g;
    int h;
    for (int p = 0; p < 4; p++) begin
      wr(8'h0c, 32'(p << 5) | 32'h8 | 32'(4 + p));
      repeat (3) wfall(g, h);
      chk(g, 65536 >> (4 + p));
      chk(h >= (2 << p) - 2 && h <= (2 << p) + 2, 1'b1);
    end
    wr(8'h0c, 32'h6f);
    wfall(g, h);
    for (int k = 0; k < 4; k++) begin
      drv_lvl <= k[0] ? 3'h7 : 3'h0;
      wfall(g, h);
    end
    rdc(8'h30, 32'h0);
    drv_lvl <= 3'h0;
    repeat (2) wfall(g, h);
    repeat (3) @(posedge clk);
    rdc(8'h34, 32'h7);
    rdc(8'h30, 32'h7);
    drv_lvl <= 3'h7;
    wr(8'h0c, 32'h7f);
    wfall(g, h);
    drv_lvl <= 3'h0;
    repeat (7) wfall(g, h);
    rdc(8'h30, 32'h0);
    wfall(g, h);
    repeat (3) @(posedge clk);
    rdc(8'h30, 32'h7);
  endtask
  task automatic t_edge();
    logic [31:0] d;
    wr(8'h0c, 32'h07);
    repeat (600) @(posedge clk);
    rd(8'h30, d);
    drv_lvl <= 3'h1;
    repeat (600) @(posedge clk);
    rdc(8'h30, 32'h1);
    wr(8'h04, 32'h0100_0000);
    repeat (600) @(posedge clk);
    drv_lvl <= 3'h0;
    repeat (600) @(posedge clk);
    rdc(8'h30, 32'h1);
  endtask
  task automatic t_mask();
    wr(8'h2c, 32'h0);
    wr(8'h04, 32'h0001_0101);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      ext_active_evt <= 3'h1;
      @(posedge clk);
      ext_active_evt <= 3'h0;
      #1 chk(tamper_trigger, 1'b1);
      chk(bkp_erase_req, m);
      repeat (2) @(posedge clk);
      rdc(8'h30, m);
      wr(8'h04, 32'h0000_0100);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_int();
    t_filt();
    t_edge();
    t_mask();
    finish_test();
  end
endmodule
bind tsf_top tsf_properties u_props (.clk(clk), .sys_rst(sys_rst), .slow_tick(slow_tick),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ext_active_evt(ext_active_evt), .int_src_evt(int_src_evt),
  .pullup_en(pullup_en), .tamper_irq(tamper_irq), .tamper_trigger(tamper_trigger),
  .bkp_erase_req(bkp_erase_req));
`default_nettype wire
